// [design/gli_pkg.sv]
// Package for the general pin and status lamp block.
// Assumes one 25 MHz clock and an asynchronous active-low reset.
package gli_pkg;

  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int unsigned PIN_COUNT = 3;
  localparam int unsigned CLK_FREQ_HZ = 25000000;
  localparam int unsigned LAMP_INTERVAL_MS = 80;
  // 80 ms at 25 MHz, exact
  localparam int unsigned LAMP_INTERVAL_CYC = (CLK_FREQ_HZ / 1000) * LAMP_INTERVAL_MS;
  localparam int unsigned LAMP_CNT_W = 21;

  // ----------------------------------------
  // Pin positions of the lamps
  // ----------------------------------------
  localparam int unsigned SPEED_LAMP_POS = 0;
  localparam int unsigned LINK_ACT_LAMP_POS = 1;
  localparam int unsigned DUPLEX_LAMP_POS = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [2:0] PIN_OUT_RST = 3'h7;
  localparam logic [2:0] PIN_OE_RST = 3'h0;
  localparam logic [2:0] PIN_IN_RST = 3'h0;

  // ----------------------------------------
  // Per-pin mode
  // ----------------------------------------
  typedef enum logic [1:0] {
    GLI_MODE_INPUT = 2'h0,
    GLI_MODE_PUSH_PULL = 2'h1,
    GLI_MODE_OPEN_DRAIN = 2'h2,
    GLI_MODE_LAMP = 2'h3
  } gli_mode_t;

  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic full_duplex;
    logic activity;
  } gli_link_status_t;

  typedef enum logic [1:0] {
    GLI_ACT_IDLE,
    GLI_ACT_OFF,
    GLI_ACT_ON_HOLD
  } gli_act_state_t;

endpackage

// [design/gli_gpio_led.sv]
// General pins with status lamp multiplexing and the link-activity blinker.
// Assumes all inputs are synchronous to clk; mode bits come from a host register.
// Notes on behaviour
// - Each of three pins is input, push-pull output, open-drain output or lamp.
// - Lamp pins only pull low or release, never drive high.
// - Speed lamp low while link runs at 100 Mb.
// - Speed lamp high during negotiation, no cable, or 10 Mb.
// - Link-activity lamp low while linked and no blink running.
// - Activity while linked turns link-activity lamp off for 80 ms.
// - After each off pulse, lamp stays on at least 80 ms before next.
// - Duplex lamp low in full duplex, inactive otherwise.
`timescale 1ns/1ns
`default_nettype none

module gli_gpio_led #(
  parameter int unsigned LAMP_INTERVAL_CYC = gli_pkg::LAMP_INTERVAL_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire gli_pkg::gli_mode_t [2:0] pin_mode,
  input wire logic [2:0] pin_out_val,
  input wire gli_pkg::gli_link_status_t link_status,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  output logic [2:0] pin_in_val,
  output logic [2:0] status_lamps_n
);

  // ----------------------------------------
  // Link status fields
  // ----------------------------------------
  logic link_up;
  logic speed_100;
  logic full_duplex;
  logic activity;

  assign link_up = link_status.link_up;
  assign speed_100 = link_status.speed_100;
  assign full_duplex = link_status.full_duplex;
  assign activity = link_status.activity;

  // ----------------------------------------
  // Interval counter
  // ----------------------------------------
  // Counts 0 to LAMP_INTERVAL_CYC-1, once for the off phase
  // and once more for the guaranteed on phase.
  // The width holds 80 ms of the 25 MHz clock; a longer
  // interval needs a wider counter.
  logic [gli_pkg::LAMP_CNT_W-1:0] cnt_q;
  logic [gli_pkg::LAMP_CNT_W-1:0] cnt_d;
  logic [gli_pkg::LAMP_CNT_W-1:0] cnt_last;
  logic [gli_pkg::LAMP_CNT_W-1:0] cnt_inc;
  logic cnt_done;

  assign cnt_last = gli_pkg::LAMP_CNT_W'(LAMP_INTERVAL_CYC - 1);
  assign cnt_inc = cnt_q + 1'b1;
  assign cnt_done = (cnt_q == cnt_last);

  // ----------------------------------------
  // Activity blinker state
  // ----------------------------------------
  gli_pkg::gli_act_state_t act_q;
  gli_pkg::gli_act_state_t act_d;
  logic in_idle;
  logic in_off;
  logic in_hold;
  logic blink_start;

  assign in_idle = (act_q == gli_pkg::GLI_ACT_IDLE);
  assign in_off = (act_q == gli_pkg::GLI_ACT_OFF);
  assign in_hold = (act_q == gli_pkg::GLI_ACT_ON_HOLD);
  // Activity is only looked at once the on phase is over
  assign blink_start = in_idle & link_up & activity;

  always_comb begin
    act_d = act_q;
    cnt_d = cnt_q;
    unique case (act_q)
      gli_pkg::GLI_ACT_IDLE: begin
        if (blink_start) begin
          act_d = gli_pkg::GLI_ACT_OFF;
          cnt_d = '0;
        end
      end

      gli_pkg::GLI_ACT_OFF: begin
        cnt_d = cnt_inc;
        if (cnt_done) begin
          act_d = gli_pkg::GLI_ACT_ON_HOLD;
          cnt_d = '0;
        end
      end

      gli_pkg::GLI_ACT_ON_HOLD: begin
        cnt_d = cnt_inc;
        // Guaranteed on time before any further blink
        if (cnt_done && in_hold) begin
          act_d = gli_pkg::GLI_ACT_IDLE;
          cnt_d = '0;
        end
      end

      default: begin
        act_d = gli_pkg::GLI_ACT_IDLE;
        cnt_d = '0;
      end
    endcase
    // Link loss ends any blink at once, so a new link
    // starts with the lamp solid on
    if (!link_up) begin
      act_d = gli_pkg::GLI_ACT_IDLE;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act_q <= gli_pkg::GLI_ACT_IDLE;
      cnt_q <= '0;
    end else begin
      act_q <= act_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------
  // Lamp levels
  // ----------------------------------------
  // Lamp levels are active low, as on the pins.
  // Auto-negotiation and no cable both show as link down
  logic speed_lamp_n;
  logic link_activity_lamp_n;
  logic duplex_lamp_n;
  logic [2:0] lamp_n;

  assign speed_lamp_n = ~(link_up & speed_100);
  assign duplex_lamp_n = ~(link_up & full_duplex);
  assign link_activity_lamp_n = ~link_up | in_off;
  assign lamp_n = {duplex_lamp_n, link_activity_lamp_n, speed_lamp_n};

  // ----------------------------------------
  // Pin drive decode
  // ----------------------------------------
  // Returns {output value, output enable} for one pin
  function automatic logic [1:0] pin_drive(
    input gli_pkg::gli_mode_t mode,
    input logic val,
    input logic lamp
  );
    logic [1:0] drv;
    drv = 2'h2;
    unique case (mode)
      gli_pkg::GLI_MODE_INPUT: begin
        // Released; the output value is parked high
        drv = 2'h2;
      end
      gli_pkg::GLI_MODE_PUSH_PULL: begin
        drv = {val, 1'h1};
      end
      gli_pkg::GLI_MODE_OPEN_DRAIN: begin
        drv = {1'h0, ~val};
      end
      gli_pkg::GLI_MODE_LAMP: begin
        // Drive low only; the pull-up makes the high
        drv = {1'h0, ~lamp};
      end
    endcase
    return drv;
  endfunction

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  logic [1:0] drv0;
  logic [1:0] drv1;
  logic [1:0] drv2;
  logic [2:0] out_d;
  logic [2:0] oe_d;

  assign drv0 = pin_drive(pin_mode[0], pin_out_val[0], lamp_n[0]);
  assign drv1 = pin_drive(pin_mode[1], pin_out_val[1], lamp_n[1]);
  assign drv2 = pin_drive(pin_mode[2], pin_out_val[2], lamp_n[2]);
  assign out_d = {drv2[1], drv1[1], drv0[1]};
  assign oe_d = {drv2[0], drv1[0], drv0[0]};

  // ----------------------------------------
  // Registered pin and lamp outputs
  // ----------------------------------------
  // Lamp levels leave on their own port whatever the pin
  // mode, so the status registers can still show them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out <= gli_pkg::PIN_OUT_RST;
      pin_oe <= gli_pkg::PIN_OE_RST;
      status_lamps_n <= gli_pkg::PIN_OUT_RST;
    end else begin
      pin_out <= out_d;
      pin_oe <= oe_d;
      status_lamps_n <= lamp_n;
    end
  end

  // ----------------------------------------
  // Input sampling
  // ----------------------------------------
  // Inputs are taken as synchronous; no extra stage here.
  // Levels for the status registers read by software
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_in_val <= gli_pkg::PIN_IN_RST;
    end else begin
      pin_in_val <= pin_in;
    end
  end

endmodule

`default_nettype wire

// [verification/gli_gpio_led_assertions.sv]
// Checker for the general pin and lamp block.
// Assumes binding to gli_gpio_led; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module gli_gpio_led_assertions #(
  parameter int unsigned LAMP_INTERVAL_CYC = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire gli_pkg::gli_mode_t [2:0] pin_mode,
  input wire logic [2:0] pin_out_val,
  input wire gli_pkg::gli_link_status_t link_status,
  input wire logic [2:0] pin_in,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] pin_in_val,
  input wire logic [2:0] status_lamps_n
);
  localparam int N = LAMP_INTERVAL_CYC;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  pp_drive_a: assert property (pin_mode[0] == gli_pkg::GLI_MODE_PUSH_PULL |=>
    pin_oe[0] && pin_out[0] == $past(pin_out_val[0])) else $error("push-pull pin");
  od_drive_a: assert property (pin_mode[1] == gli_pkg::GLI_MODE_OPEN_DRAIN |=>
    !pin_out[1] && pin_oe[1] != $past(pin_out_val[1])) else $error("open-drain pin");
  in_release_a: assert property (pin_mode[2] == gli_pkg::GLI_MODE_INPUT |=>
    pin_out[2] && !pin_oe[2]) else $error("input pin driven");
  lamp_no_high_a: assert property (pin_mode[0] == gli_pkg::GLI_MODE_LAMP |=>
    !pin_out[0]) else $error("lamp pin driven high");
  speed_lamp_a: assert property (1 |=> status_lamps_n[0] !=
    ($past(link_status.link_up) && $past(link_status.speed_100))) else $error("speed lamp");
  duplex_lamp_a: assert property (link_status.link_up && link_status.full_duplex |=>
    !status_lamps_n[2]) else $error("duplex lamp");
  link_down_a: assert property (!link_status.link_up |=> status_lamps_n[1])
    else $error("link lamp on without link");
  // A link loss cuts the off pulse short, so it ends the check
  off_len_a: assert property (disable iff (!rst_b || !link_status.link_up)
    $rose(status_lamps_n[1]) && $past(link_status.link_up) |->
    ##N $fell(status_lamps_n[1])) else $error("off pulse length");
  in_sample_a: assert property (1 |=> pin_in_val == $past(pin_in))
    else $error("input sample");
  blink_c: cover property ($rose(status_lamps_n[1]) && link_status.link_up);
  speed_c: cover property (!status_lamps_n[0]);
  od_c: cover property (pin_mode[1] == gli_pkg::GLI_MODE_OPEN_DRAIN);
endmodule
`default_nettype wire

// [verification/gli_pins_model.sv]
// Pin load model: pull-ups on all pins, optional external pull-down.
// Assumes the block's split pin ports; resolves the level seen at pin_in.
`timescale 1ns/1ns
`default_nettype none
module gli_pins_model (
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] ext_low,
  output logic [2:0] pin_in
);
  // Released pins float up; the external pull-down wins over a high drive
  assign pin_in = ~ext_low & (~pin_oe | pin_out);
endmodule
`default_nettype wire

// [verification/gli_gpio_led_tb.sv]
// Testbench for the general pin and lamp block.
// Assumes gli_pins_model as the pin load and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module gli_gpio_led_tb;
  logic clk = 0;
  logic rst_b = 0;
  logic e;
  logic [2:0] pin_out_val = 3'h5;
  logic [2:0] ext_low = 3'h2;
  logic [2:0] pin_out, pin_oe, pin_in_val, status_lamps_n, pin_in;
  gli_pkg::gli_mode_t [2:0] pin_mode;
  gli_pkg::gli_link_status_t ls = 4'h0;
  int mismatches = 0;
  int checked = 0;
  gli_gpio_led #(.LAMP_INTERVAL_CYC(8)) dut (.clk, .rst_b, .pin_mode, .pin_out_val,
    .link_status(ls), .pin_in, .pin_out, .pin_oe, .pin_in_val, .status_lamps_n);
  gli_pins_model pins (.pin_out, .pin_oe, .ext_low, .pin_in);
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic t_modes();
    logic [2:0] eo[4] = '{3'h7, 3'h5, 3'h0, 3'h0};
    logic [2:0] eoe[4] = '{3'h0, 3'h7, 3'h2, 3'h0};
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 3; i++) pin_mode[i] = gli_pkg::gli_mode_t'(k);
      @(negedge clk);
      if (k == 0) chk(pin_in_val, 3'h5);
      chk(pin_out, eo[k]);
      chk(pin_oe, eoe[k]);
    end
  endtask
  task automatic t_lamps();
    gli_pkg::gli_link_status_t st[3] = '{4'he, 4'h8, 4'h0};
    logic [2:0] ex[3] = '{3'h0, 3'h5, 3'h7};
    for (int k = 0; k < 3; k++) begin
      ls = st[k];
      @(negedge clk);
      chk(status_lamps_n, ex[k]);
    end
  endtask
  // Activity held high: second blink only after the full on phase
  task automatic t_blink();
    ls = 4'h8;
    @(negedge clk);
    ls = 4'h9;
    for (int i = 0; i < 19; i++) begin
      @(negedge clk);
      e = (i > 0 && i < 9) || i == 18;
      chk(status_lamps_n, {1'h1, e, 1'h1});
      chk(pin_oe, {1'h0, !e, 1'h0});
    end
    ls = 4'h1;
    @(negedge clk);
    chk(status_lamps_n, 3'h7);
    ls = 4'h8;
    @(negedge clk);
    chk(status_lamps_n, 3'h5);
  endtask
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    #20000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    for (int i = 0; i < 3; i++) pin_mode[i] = gli_pkg::GLI_MODE_INPUT;
    repeat (20) @(negedge clk);
    chk(status_lamps_n, 3'h7);
    chk(pin_oe, 3'h0);
    rst_b = 1;
    t_modes();
    t_lamps();
    t_blink();
    tally_and_finish();
  end
endmodule
bind gli_gpio_led gli_gpio_led_assertions #(.LAMP_INTERVAL_CYC(LAMP_INTERVAL_CYC)) u_chk (
  .clk, .rst_b, .pin_mode, .pin_out_val, .link_status, .pin_in, .pin_out, .pin_oe,
  .pin_in_val, .status_lamps_n);
`default_nettype wire
